/* rtl/hbridge_params.svh */
`ifndef HBRIDGE_PARAMS_SVH
`define HBRIDGE_PARAMS_SVH

// register addresses
`define ADDR_FAULT_STATUS      6'h00
`define ADDR_DRIVE_CONFIG      6'h02
`define ADDR_PROTECTION_CONFIG 6'h03
`define ADDR_BRIDGE_COMMAND    6'h04

// reset values
`define RST_DRIVE_CONFIG       8'h51
`define RST_PROTECTION_CONFIG  8'h0C
`define RST_BRIDGE_COMMAND     8'h40

// field positions
`define FLD_SERIAL_INPUT       5
`define FLD_TRIP_REPORT        7
`define FLD_THERMAL_RECOVERY   6
`define FLD_WARNING_REPORT     5
`define FLD_PUMP_UV_DISABLE    4
`define FLD_CLEAR_FAULTS       7
`define FLD_HALF_ONE_OFF       3
`define FLD_HALF_TWO_OFF       2
`define FLD_SOFT_ONE           1
`define FLD_SOFT_TWO           0
`define FLD_GLOBAL_FAULT       6

// lock key codes
`define KEY_LOCK               3'h3
`define KEY_UNLOCK             3'h4

// retry wait times in microseconds and clock rate
`define RETRY_US_0             500
`define RETRY_US_1             1000
`define RETRY_US_2             2000
`define RETRY_US_3             4000
`define CLK_MHZ                25

`endif

/* rtl/hbridge_pkg.sv */
package hbridge_pkg;

   typedef enum logic [1:0] {
      MODE_PHASE_ENABLE,
      MODE_PWM,
      MODE_INDEPENDENT,
      MODE_HIZ
   } bridge_mode_t;

   typedef enum logic [1:0] {
      OCR_LATCH,
      OCR_RETRY,
      OCR_REPORT,
      OCR_IGNORE
   } oc_response_t;

   typedef struct packed {
      logic         off_time_hi;
      logic         off_time_lo;
      logic         serial_input;
      logic [2:0]   slew_select;
      bridge_mode_t mode;
   } drive_config_t;

   typedef struct packed {
      logic         trip_report_enable;
      logic         thermal_recovery_select;
      logic         warning_report_enable;
      logic         pump_undervoltage_disable;
      logic [1:0]   overcurrent_retry_time;
      oc_response_t overcurrent_response;
   } protection_config_t;

   typedef struct packed {
      logic         overcurrent;
      logic         overtemp;
      logic         overheat_warning;
      logic         pump_undervoltage;
      logic         current_trip_event;
   } fault_events_t;

endpackage : hbridge_pkg

/* rtl/hbridge_retry_timer.sv */
`timescale 1ns/1ps
`include "hbridge_params.svh"

// counts the overcurrent retry wait and pulses when it expires
module hbridge_retry_timer
   import hbridge_pkg::*;
#(
   parameter int unsigned CLK_MHZ = `CLK_MHZ
) (
   input  wire logic       i_clk,     // system clock
   input  wire logic       i_rst_n,   // synchronised reset
   input  wire logic       i_start,   // start a wait
   input  wire logic [1:0] i_sel,     // wait select
   output logic            o_busy,    // waiting
   output logic            o_done     // wait over pulse
);
   localparam int unsigned CYC0 = `RETRY_US_0 * CLK_MHZ;
   localparam int unsigned CYC1 = `RETRY_US_1 * CLK_MHZ;
   localparam int unsigned CYC2 = `RETRY_US_2 * CLK_MHZ;
   localparam int unsigned CYC3 = `RETRY_US_3 * CLK_MHZ;

   logic [16:0] count_r;
   logic [16:0] limit;

   always_comb begin
      case (i_sel)
         2'h0:    limit = 17'(CYC0);
         2'h1:    limit = 17'(CYC1);
         2'h2:    limit = 17'(CYC2);
         default: limit = 17'(CYC3);
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count_r <= 17'h00000;
         o_busy  <= 1'b0;
         o_done  <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_start && !o_busy) begin
            o_busy  <= 1'b1;
            count_r <= limit - 17'h00001;
         end else if (o_busy) begin
            if (count_r == 17'h00000) begin
               o_busy <= 1'b0;
               o_done <= 1'b1;
            end else begin
               count_r <= count_r - 17'h00001;
            end
         end
      end
   end
endmodule : hbridge_retry_timer

/* rtl/hbridge_control_registers.sv */
// Notes on behaviour
// - serial select picks soft bits over pins
// - slew select field, reset code 100b
// - mode field; 11b holds bridge high-impedance
// - trip events reported only when enabled
// - overtemp latched or auto-recovers per bit
// - overheat warning raises alarm only when enabled; status bit shows it always
// - pump undervoltage fault disable bit
// - retry wait 0.5, 1, 2, 4 ms
// - overcurrent latch, retry, report, or ignore
// - clear faults bit self-clears after write
// - key 011b locks drive config, 100b unlocks
// - half bridge off bits in independent mode
// - soft bits replace input pins
// - global fault bit mirrors alarm pin
`timescale 1ns/1ps
`include "hbridge_params.svh"

module hbridge_control_registers
   import hbridge_pkg::*;
(
   input  wire logic          i_mclk,         // 25 MHz clock
   input  wire logic          i_reset_n,      // async reset, active low
   input  wire logic          i_wr_en,        // register write strobe
   input  wire logic          i_rd_en,        // register read strobe
   input  wire logic [5:0]    i_addr,         // register address
   input  wire logic [7:0]    i_wdata,        // write data
   output logic      [7:0]    o_rdata,        // read data
   input  wire logic [1:0]    i_input_pins,   // external input pins
   input  wire fault_events_t i_events,       // raw protection conditions (pins)
   output logic      [1:0]    o_gate_in,      // bridge control inputs
   output logic      [1:0]    o_half_hiz,     // per half bridge high-z
   output bridge_mode_t       o_mode,         // interface mode
   output logic      [2:0]    o_slew_select,  // slew rate code
   output logic      [1:0]    o_off_time,     // off time select
   output logic               o_alarm_output_n// fault pin, active low
);
   logic          rst_s1_r, rst_n_r;
   logic [1:0]    pins_s1_r, pins_r;
   fault_events_t ev_s1_r, ev_r;

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pins_s1_r <= 2'h0;
         pins_r    <= 2'h0;
         ev_s1_r   <= '0;
         ev_r      <= '0;
      end else begin
         pins_s1_r <= i_input_pins;
         pins_r    <= pins_s1_r;
         ev_s1_r   <= i_events;
         ev_r      <= ev_s1_r;
      end
   end

   drive_config_t      drive_r;
   protection_config_t prot_r;
   logic [2:0]         key_r;
   logic               one_off_r, two_off_r, soft_one_r, soft_two_r;
   logic               clear_r;
   logic               locked;

   assign locked = (key_r == `KEY_LOCK);

   always_ff @(posedge i_mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         drive_r <= drive_config_t'(`RST_DRIVE_CONFIG);
      end else if (i_wr_en && i_addr == `ADDR_DRIVE_CONFIG && !locked) begin
         drive_r <= drive_config_t'(i_wdata);
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         prot_r <= protection_config_t'(`RST_PROTECTION_CONFIG);
      end else if (i_wr_en && i_addr == `ADDR_PROTECTION_CONFIG) begin
         prot_r <= protection_config_t'(i_wdata);
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         key_r      <= 3'(`RST_BRIDGE_COMMAND >> 4);
         one_off_r  <= 1'b0;
         two_off_r  <= 1'b0;
         soft_one_r <= 1'b0;
         soft_two_r <= 1'b0;
         clear_r    <= 1'b0;
      end else begin
         clear_r <= 1'b0;
         if (i_wr_en && i_addr == `ADDR_BRIDGE_COMMAND) begin
            clear_r    <= i_wdata[`FLD_CLEAR_FAULTS];
            if (i_wdata[6:4] == `KEY_LOCK || i_wdata[6:4] == `KEY_UNLOCK) begin
               key_r <= i_wdata[6:4];
            end
            one_off_r  <= i_wdata[`FLD_HALF_ONE_OFF];
            two_off_r  <= i_wdata[`FLD_HALF_TWO_OFF];
            soft_one_r <= i_wdata[`FLD_SOFT_ONE];
            soft_two_r <= i_wdata[`FLD_SOFT_TWO];
         end
      end
   end

   // protection handling
   logic oc_latch_r, ot_latch_r, uv_latch_r, oc_hold_r;
   logic retry_busy, retry_done;
   logic oc_shut, ot_shut, fault_any;

   hbridge_retry_timer u_retry (
      .i_clk   (i_mclk),
      .i_rst_n (rst_n_r),
      .i_start (ev_r.overcurrent && prot_r.overcurrent_response == OCR_RETRY),
      .i_sel   (prot_r.overcurrent_retry_time),
      .o_busy  (retry_busy),
      .o_done  (retry_done)
   );

   always_ff @(posedge i_mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         oc_latch_r <= 1'b0;
         oc_hold_r  <= 1'b0;
      end else begin
         if (ev_r.overcurrent && prot_r.overcurrent_response == OCR_LATCH) begin
            oc_latch_r <= 1'b1;
         end else if (clear_r) begin
            oc_latch_r <= 1'b0;
         end
         if (ev_r.overcurrent && prot_r.overcurrent_response == OCR_RETRY) begin
            oc_hold_r <= 1'b1;
         end else if (retry_done || prot_r.overcurrent_response != OCR_RETRY) begin
            oc_hold_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ot_latch_r <= 1'b0;
         uv_latch_r <= 1'b0;
      end else begin
         if (ev_r.overtemp) begin
            ot_latch_r <= 1'b1;
         end else if (clear_r || prot_r.thermal_recovery_select) begin
            ot_latch_r <= 1'b0;
         end
         uv_latch_r <= ev_r.pump_undervoltage && !prot_r.pump_undervoltage_disable;
      end
   end

   assign oc_shut = oc_latch_r || oc_hold_r || retry_busy;
   assign ot_shut = ot_latch_r;
   assign fault_any = oc_shut || ot_shut || uv_latch_r
                    || (ev_r.overcurrent && prot_r.overcurrent_response == OCR_REPORT)
                    || (ev_r.current_trip_event && prot_r.trip_report_enable)
                    || (ev_r.overheat_warning && prot_r.warning_report_enable);

   // output stage
   logic [1:0] gate_src;
   assign gate_src = drive_r.serial_input ? {soft_one_r, soft_two_r} : pins_r;

   always_ff @(posedge i_mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_gate_in        <= 2'h0;
         o_half_hiz       <= 2'h3;
         o_mode           <= MODE_PWM;
         o_slew_select    <= 3'h4;
         o_off_time       <= 2'h1;
         o_alarm_output_n <= 1'b1;
      end else begin
         o_gate_in     <= gate_src;
         o_mode        <= drive_r.mode;
         o_slew_select <= drive_r.slew_select;
         o_off_time    <= {drive_r.off_time_hi, drive_r.off_time_lo};
         if (drive_r.mode == MODE_HIZ || oc_shut || ot_shut || uv_latch_r) begin
            o_half_hiz <= 2'h3;
         end else if (drive_r.mode == MODE_INDEPENDENT) begin
            o_half_hiz <= {two_off_r, one_off_r};
         end else begin
            o_half_hiz <= 2'h0;
         end
         o_alarm_output_n <= !fault_any;
      end
   end

   // read path
   always_ff @(posedge i_mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_rdata <= 8'h00;
      end else if (i_rd_en) begin
         case (i_addr)
            `ADDR_FAULT_STATUS: begin
               o_rdata <= {1'b0, !o_alarm_output_n, ev_r.overheat_warning, 1'b0,
                           uv_latch_r, oc_latch_r | oc_hold_r, ot_latch_r, 1'b0};
            end
            `ADDR_DRIVE_CONFIG:      o_rdata <= drive_r;
            `ADDR_PROTECTION_CONFIG: o_rdata <= prot_r;
            `ADDR_BRIDGE_COMMAND: begin
               o_rdata <= {1'b0, key_r, one_off_r, two_off_r, soft_one_r, soft_two_r};
            end
            default:                 o_rdata <= 8'h00;
         endcase
      end
   end
endmodule : hbridge_control_registers

/* tb/hbridge_control_registers_chk.sv */
`timescale 1ns/1ps
module hbridge_control_registers_chk
   import hbridge_pkg::*;
(
   input wire logic         i_mclk,          // clk
   input wire logic         i_reset_n,       // rst
   input wire logic         i_wr_en,         // wr
   input wire logic         i_rd_en,         // rd
   input wire logic [5:0]   i_addr,          // addr
   input wire logic [7:0]   i_wdata,         // wdata
   input wire logic [7:0]   o_rdata,         // rdata
   input wire logic [1:0]   i_input_pins,    // pins
   input wire logic [1:0]   o_gate_in,       // gate
   input wire logic [1:0]   o_half_hiz,      // hi-z
   input wire bridge_mode_t o_mode,          // mode
   input wire logic [2:0]   o_slew_select,   // slew
   input wire logic [1:0]   o_off_time,      // off
   input wire logic         o_alarm_output_n // alarm
);
   logic       lock_r;
   logic       ser_r;
   logic [1:0] soft_r;
   logic [1:0] off_r;
   logic       wr_drv;
   logic       wr_cmd;
   assign wr_drv = i_wr_en && i_addr == 6'h02;
   assign wr_cmd = i_wr_en && i_addr == 6'h04;
   // shadow of the fields that steer the outputs
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         lock_r <= 1'b0;
         ser_r  <= 1'b0;
         soft_r <= 2'h0;
         off_r  <= 2'h0;
      end else begin
         if (wr_drv && !lock_r) ser_r <= i_wdata[5];
         if (wr_cmd) soft_r <= i_wdata[1:0];
         if (wr_cmd) off_r <= i_wdata[3:2];
         if (wr_cmd && i_wdata[6:4] == 3'h3) lock_r <= 1'b1;
         if (wr_cmd && i_wdata[6:4] == 3'h4) lock_r <= 1'b0;
      end
   end
   default clocking @(posedge i_mclk);
   endclocking
   default disable iff (!i_reset_n);
   reset_values_a: assert property ($rose(i_reset_n) |->
      o_mode == MODE_PWM && o_slew_select == 3'h4 && o_off_time == 2'h1 && o_half_hiz == 2'h3)
      else $error("outputs not at reset values");
   drive_write_a: assert property ((wr_drv && !lock_r ##1 !i_wr_en [*3]) |=>
      {o_off_time, o_slew_select, o_mode} == {$past(i_wdata[7:6], 4), $past(i_wdata[4:0], 4)})
      else $error("drive fields not taken");
   lock_hold_a: assert property (wr_drv && lock_r |=> $stable({o_off_time, o_slew_select, o_mode}) [*4])
      else $error("locked drive fields changed");
   pin_follow_a: assert property ((!ser_r && $stable(i_input_pins) && o_mode == MODE_PWM) [*8] |->
      o_gate_in == i_input_pins)
      else $error("gate not following pins");
   soft_follow_a: assert property ((ser_r && $stable(soft_r) && o_mode == MODE_PWM) [*6] |->
      o_gate_in == soft_r)
      else $error("gate not following soft bits");
   half_off_a: assert property ((o_mode == MODE_INDEPENDENT && $stable(off_r)) [*6] |->
      (o_half_hiz & {off_r[0], off_r[1]}) == {off_r[0], off_r[1]})
      else $error("half bridge not off");
   hiz_mode_a: assert property (o_mode == MODE_HIZ [*3] |-> o_half_hiz == 2'h3)
      else $error("bridge not hi-z");
   alarm_mirror_a: assert property (($stable(o_alarm_output_n) [*3] ##0 (i_rd_en && i_addr == 6'h00)) |=>
      o_rdata[6] == !$past(o_alarm_output_n))
      else $error("global fault differs from alarm");
endmodule : hbridge_control_registers_chk

bind hbridge_control_registers hbridge_control_registers_chk hbridge_control_registers_chk_i (
   .i_mclk, .i_reset_n, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .o_rdata, .i_input_pins,
   .o_gate_in, .o_half_hiz, .o_mode, .o_slew_select, .o_off_time, .o_alarm_output_n
);

/* tb/host_model.sv */
`timescale 1ns/1ps
module host_model (
   input  wire logic       i_mclk,  // clk
   input  wire logic [7:0] i_rdata, // rdata
   output logic            o_wr_en, // wr
   output logic            o_rd_en, // rd
   output logic      [5:0] o_addr,  // addr
   output logic      [7:0] o_wdata  // wdata
);
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr  = 6'h3F;
      o_wdata = 8'hFF;
   end
   // clear bit goes out once and is never written back; key goes whole
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge i_mclk);
      o_addr  = a;
      o_wdata = d;
      o_wr_en = 1'b1;
      @(negedge i_mclk);
      o_wr_en = 1'b0;
      o_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(negedge i_mclk);
      o_addr  = a;
      o_rd_en = 1'b1;
      @(negedge i_mclk);
      o_rd_en = 1'b0;
      d       = i_rdata;
   endtask : rd
endmodule : host_model

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import hbridge_pkg::*;
;
   logic          i_mclk;
   logic          i_reset_n;
   logic          i_wr_en;
   logic          i_rd_en;
   logic [5:0]    i_addr;
   logic [7:0]    i_wdata;
   logic [7:0]    o_rdata;
   logic [1:0]    i_input_pins;
   fault_events_t i_events;
   logic [1:0]    o_gate_in;
   logic [1:0]    o_half_hiz;
   bridge_mode_t  o_mode;
   logic [2:0]    o_slew_select;
   logic [1:0]    o_off_time;
   logic          o_alarm_output_n;
   int            n_errors = 0;
   int            checks   = 0;
   int            cycles   = 0;
   logic [31:0]   seed     = 32'hFB17;
   logic [7:0]    d;
   logic [31:0]   r;
   logic [15:0]   e;
   localparam int RETRY_CYC = 500 * 25;
   logic [15:0]   rst_tab[5] = '{16'h0000, 16'h0251, 16'h030C, 16'h0440, 16'h0700};
   logic [7:0]    modes[4]   = '{8'hAE, 8'hB1, 8'hA3, 8'hA0};
   // config, event, alarm while raised, alarm after drop (2 = not checked)
   logic [15:0]   ev_tab[11] = '{16'h0C25, 16'h2C21, 16'h0C0D, 16'h8C0A, 16'h0C11, 16'h1C15,
                                 16'h0F85, 16'h0E82, 16'h0C80, 16'h0C40, 16'h4C41};
   hbridge_control_registers hbridge_control_registers_i (
      .i_mclk, .i_reset_n, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .o_rdata, .i_input_pins,
      .i_events, .o_gate_in, .o_half_hiz, .o_mode, .o_slew_select, .o_off_time, .o_alarm_output_n
   );
   host_model host_model_i (.i_mclk, .i_rdata(o_rdata), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
                            .o_addr(i_addr), .o_wdata(i_wdata));
   function automatic logic [31:0] next_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : next_rand
   function automatic logic [1:0] expect_hiz(input logic [1:0] m, input logic [1:0] off);
      if (m == 2'h3) return 2'h3;
      if (m == 2'h2) return {off[0], off[1]};
      return 2'h0;
   endfunction : expect_hiz
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   initial begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 60000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial begin
      i_reset_n    = 1'b0;
      i_input_pins = 2'h0;
      i_events     = '0;
      repeat (16) @(negedge i_mclk);
      i_reset_n = 1'b1;
      repeat (4) @(negedge i_mclk);
      foreach (rst_tab[i]) begin
         host_model_i.rd(rst_tab[i][13:8], d);
         chk("reset value", rst_tab[i][7:0], d);
      end
      $display("test reset values done");
      for (int i = 0; i < 12; i++) begin
         r = next_rand();
         i_input_pins = r[17:16];
         host_model_i.wr(6'h03, r[7:0]);
         host_model_i.rd(6'h03, d);
         chk("protection", r[7:0], d);
         host_model_i.wr(6'h02, r[15:8]);
         repeat (4) @(negedge i_mclk);
         host_model_i.rd(6'h02, d);
         chk("drive", r[15:8], d);
         chk("slew mode", {3'h0, r[12:8]}, {3'h0, o_slew_select, o_mode});
         chk("hi-z", {6'h0, expect_hiz(r[9:8], 2'h0)}, {6'h0, o_half_hiz});
         if (r[9:8] == 2'h1 && !r[13]) chk("pin gate", {6'h0, r[17:16]}, {6'h0, o_gate_in});
      end
      $display("test random access done");
      host_model_i.wr(6'h02, 8'h51);
      host_model_i.wr(6'h04, 8'h30);
      host_model_i.wr(6'h02, 8'hAE);
      repeat (4) @(negedge i_mclk);
      host_model_i.rd(6'h02, d);
      chk("locked", 8'h51, d);
      host_model_i.rd(6'h04, d);
      chk("key", 8'h30, d);
      host_model_i.wr(6'h04, 8'h40);
      host_model_i.wr(6'h02, 8'hAE);
      repeat (4) @(negedge i_mclk);
      host_model_i.rd(6'h02, d);
      chk("unlocked", 8'hAE, d);
      $display("test lock done");
      foreach (modes[m]) begin
         host_model_i.wr(6'h02, modes[m]);
         for (int k = 0; k < 16; k++) begin
            host_model_i.wr(6'h04, 8'h40 | k[7:0]);
            repeat (6) @(negedge i_mclk);
            chk("half hi-z", {6'h0, expect_hiz(modes[m][1:0], k[3:2])}, {6'h0, o_half_hiz});
            if (modes[m][1:0] == 2'h1) chk("soft gate", {6'h0, k[1:0]}, {6'h0, o_gate_in});
         end
      end
      host_model_i.wr(6'h02, 8'h91);
      for (int k = 0; k < 6; k++) begin
         r = next_rand();
         i_input_pins = r[1:0];
         repeat (10) @(negedge i_mclk);
         chk("pin gate", {6'h0, r[1:0]}, {6'h0, o_gate_in});
      end
      $display("test modes and inputs done");
      foreach (ev_tab[i]) begin
         e = ev_tab[i];
         host_model_i.wr(6'h03, e[15:8]);
         i_events = e[7:3];
         repeat (8) @(negedge i_mclk);
         chk("alarm raised", {7'h0, e[2]}, {7'h0, o_alarm_output_n});
         host_model_i.rd(6'h00, d);
         chk("global fault", {7'h0, ~e[2]}, {7'h0, d[6]});
         i_events = '0;
         repeat (8) @(negedge i_mclk);
         if (e[1:0] != 2'h2) chk("alarm held", {7'h0, e[0]}, {7'h0, o_alarm_output_n});
         host_model_i.wr(6'h04, 8'hC0);
         repeat (8) @(negedge i_mclk);
         chk("alarm cleared", 8'h01, {7'h0, o_alarm_output_n});
         host_model_i.rd(6'h04, d);
         chk("clear bit", 8'h40, d);
      end
      $display("test fault handling done");
      // retry codes 00b and 01b: each wait doubles the one before
      for (int t = 0; t < 2; t++) begin
         host_model_i.wr(6'h03, {4'h0, t[1:0], 2'h1});
         i_events = 5'h10;
         repeat (4) @(negedge i_mclk);
         i_events = '0;
         repeat (8) @(negedge i_mclk);
         chk("retry off", 8'h03, {6'h0, o_half_hiz});
         repeat ((RETRY_CYC << t) - 40) @(negedge i_mclk);
         chk("retry wait", 8'h03, {6'h0, o_half_hiz});
         repeat (80) @(negedge i_mclk);
         chk("retry over", 8'h00, {6'h0, o_half_hiz});
      end
      $display("test retry done");
      tally_and_finish();
   end
endmodule : tb_top
